// file: ipic_core_model.sv
// processor core model that takes each presented request
`timescale 1ns/1ps
`default_nettype none
module ipic_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // request from the controller
    input  wire logic       req_valid,
    input  wire logic [2:0] req_src,
    input  wire logic [2:0] req_level,
    input  wire logic       nmi_req,
    // last request taken and nmi seen
    output ipic_pkg::ipic_req_t taken,
    output logic            nmi_seen
);
    // latch the winner each cycle; the core has no acknowledge,
    // so clearing the source flag is left to software
    always_ff @(posedge clk) begin
        if (rst) begin
            taken    <= '0;
            nmi_seen <= 1'b0;
        end else begin
            taken    <= {req_valid, req_src, req_level};
            nmi_seen <= nmi_req;
        end
    end
endmodule
`default_nettype wire

// file: ipic_pin_sense.sv
// pin synchroniser, glitch filter and sense-condition detector
`timescale 1ns/1ps
`default_nettype none
module ipic_pin_sense #(
    parameter int N = 8
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // raw pins and per-pin sense codes
    input  wire logic [N-1:0]   pin,
    input  wire logic [2*N-1:0] sense,
    // filtered level and detect: a one-cycle pulse per edge, held while a low-level pin stays low
    output logic      [N-1:0]   level,
    output logic      [N-1:0]   detect
);
    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [N-1:0] s3_r;
    logic [N-1:0] stable_r;
    logic [N-1:0] stable_nxt;

    // three stages; pins idle high, so reset to ones
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r     <= '1;
            s2_r     <= '1;
            s3_r     <= '1;
            stable_r <= '1;
        end else begin
            s1_r     <= pin;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= stable_nxt;
        end
    end

    // a change counts only once stages two and three agree
    always_comb begin
        stable_nxt = (s2_r & s3_r) | (stable_r & (s2_r | s3_r));
    end

    assign level = stable_r;

    // decode each pin's condition
    always_comb begin
        detect = '0;
        for (int i = 0; i < N; i++) begin
            case (sense[2*i +: 2])
                ipic_pkg::SENSE_LOW_LEVEL: detect[i] = ~stable_r[i];
                ipic_pkg::SENSE_FALL:
                    detect[i] = stable_r[i] & ~stable_nxt[i];
                ipic_pkg::SENSE_RISE:
                    detect[i] = ~stable_r[i] & stable_nxt[i];
                ipic_pkg::SENSE_BOTH:
                    detect[i] = stable_r[i] ^ stable_nxt[i];
                default: detect[i] = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: ipic_pkg.sv
// package: register map, field layout, reset values and carriers
//
// Overview of operation
// - mode field 00 selects mode 0, 10 selects mode 2; 01, 11 prohibited
// - nonmaskable edge select: 0 falling edge, 1 rising edge raises request
// - manual reset select bit: 0 disables, 1 enables manual reset input
// - ram enable bit: 0 disables, 1 enables the on-chip ram
// - each priority register holds two 3-bit fields, bits 6:4 and 2:0
// - field 111 gives level 7 highest, 000 level 0 lowest, linear between
// - after reset every priority field reads level 7
// - one independent request enable per external pin, pins 7 to 0
// - sense registers high and low choose each pin's request condition
// - both-edge sense raises a request on every rising and falling edge
// - a detected pin condition sets that pin's flag in request status; the code sets it only for pins whose request enable is 1
// - requests from a pin with enable 0 are blocked, enable 1 passed
// - pin 0 sense bits 11 in low sense register select both edges
// - a flag reads 0 until its condition is seen; all reset to 0
package ipic_pkg;

    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_SYSTEM_CONTROL = 30'h00fffde5;
    localparam logic [29:0] IDX_PRIO_A         = 30'h00fffec0;
    localparam logic [29:0] IDX_PRIO_B         = 30'h00fffec1;
    localparam logic [29:0] IDX_PRIO_C         = 30'h00fffec2;
    localparam logic [29:0] IDX_PRIO_D         = 30'h00fffec3;
    localparam logic [29:0] IDX_SENSE_HIGH     = 30'h00fffe12;
    localparam logic [29:0] IDX_SENSE_LOW      = 30'h00fffe13;
    localparam logic [29:0] IDX_PIN_ENABLE     = 30'h00fffe14;
    localparam logic [29:0] IDX_PIN_STATUS     = 30'h00fffe15;
    localparam logic [29:0] IDX_EVENT_STATUS   = 30'h00fffe20;
    localparam logic [29:0] IDX_EVENT_MASK     = 30'h00fffe21;

    // system control field positions
    localparam int SC_MODE_HI  = 5;
    localparam int SC_MODE_LO  = 4;
    localparam int SC_NMI_EDGE = 3;
    localparam int SC_MRST_EN  = 2;
    localparam int SC_RAM_EN   = 0;
    localparam logic [7:0] SC_WMASK = 8'h3d;
    localparam logic [7:0] SC_RESET = 8'h01;

    // interrupt control modes
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_2 = 2'h2;

    // priority fields
    localparam int PRIO_HI_LSB = 4;
    localparam int PRIO_LO_LSB = 0;
    localparam logic [7:0] PRIO_WMASK = 8'h77;
    localparam logic [7:0] PRIO_RESET = 8'h77;

    // pin sense codes, two bits per pin
    localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
    localparam logic [1:0] SENSE_FALL      = 2'h1;
    localparam logic [1:0] SENSE_RISE      = 2'h2;
    localparam logic [1:0] SENSE_BOTH      = 2'h3;

    // event status bits
    localparam int EV_NMI      = 0;
    localparam int EV_PIN      = 1;
    localparam int EV_BAD_MODE = 2;
    localparam int EV_W        = 3;

    localparam logic [7:0] REG8_ZERO = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

    // request presented to the core
    typedef struct packed {
        logic       valid;
        logic [2:0] src;
        logic [2:0] level;
    } ipic_req_t;

    // captured ahb address phase
    typedef struct packed {
        logic        write;
        logic [29:0] idx;
    } ipic_cmd_t;

endpackage

// file: ipic_pkg_note_placeholder_never_used.sv
// this file holds no code

// file: ipic_prio_resolve.sv
// picks the pending request of highest level
`timescale 1ns/1ps
`default_nettype none
module ipic_prio_resolve #(
    parameter int N = 8
) (
    // pending requests and 3-bit levels, source i at [3i+2:3i]
    input  wire logic [N-1:0]   pend,
    input  wire logic [3*N-1:0] levels,
    input  wire logic           use_levels,
    // winner
    output ipic_pkg::ipic_req_t win
);
    logic [2:0] lvl;
    logic [2:0] eff;
    logic [2:0] best;

    // scan from the top so lower indices win ties
    always_comb begin
        win  = '0;
        best = 3'h0;
        lvl  = 3'h0;
        eff  = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            lvl = levels[3*i +: 3];
            // mode 0 ignores levels: order alone decides
            eff = use_levels ? lvl : 3'h0;
            if (pend[i] && (!win.valid || eff >= best)) begin
                win.valid = 1'b1;
                win.src   = 3'(i);
                win.level = lvl;
                best      = eff;
            end
        end
    end
endmodule
`default_nettype wire

// file: ipic_props.sv
// assertion checker for the pin interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module ipic_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    // pins and core side
    input wire logic        nonmask_pin,
    input wire logic        manual_reset_pin,
    input wire logic        core_req_valid,
    input wire logic        nonmask_req,
    input wire logic [1:0]  int_mode,
    input wire logic        manual_reset_out,
    input wire logic        onchip_ram_enable
);
    logic take;
    logic sc_wr_r;
    // a transfer is taken when selected, ready and nonsequential or sequential
    assign take = hsel && hready && htrans[1];
    // marks the data phase of a system control write
    always_ff @(posedge clk) begin
        sc_wr_r <= !rst && take && hwrite &&
                   haddr[31:2] == ipic_pkg::IDX_SYSTEM_CONTROL;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence rd_take; take && !hwrite; endsequence
    sequence rd_answer; !hreadyout ##1 hreadyout; endsequence
    mode_legal_a: assert property (int_mode != 2'h1 && int_mode != 2'h3)
        else $error("mode output holds a prohibited code");
    mode_write_a: assert property (sc_wr_r && !hwdata[4] |=>
        int_mode == $past(hwdata[5:4])) else $error("mode not written");
    mode_keep_a: assert property (sc_wr_r && hwdata[4] |=>
        $stable(int_mode)) else $error("prohibited mode was taken");
    ram_write_a: assert property (sc_wr_r |=>
        onchip_ram_enable == $past(hwdata[0])) else $error("ram enable");
    mrst_idle_a: assert property (manual_reset_pin [*8] |=>
        !manual_reset_out) else $error("manual reset without low pin");
    nmi_quiet_a: assert property ($stable(nonmask_pin) [*8] |=>
        !$rose(nonmask_req)) else $error("nmi request without edge");
    reset_clear_a: assert property (disable iff (1'b0)
        rst |=> !core_req_valid && !nonmask_req && onchip_ram_enable)
        else $error("outputs not cleared by reset");
    read_wait_a: assert property (rd_take |=> rd_answer)
        else $error("read answer timing wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    rdata_width_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
endmodule
bind ipic_top ipic_props ipic_props_i (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .nonmask_pin(nonmask_pin),
    .manual_reset_pin(manual_reset_pin), .core_req_valid(core_req_valid),
    .nonmask_req(nonmask_req), .int_mode(int_mode),
    .manual_reset_out(manual_reset_out),
    .onchip_ram_enable(onchip_ram_enable)
);
`default_nettype wire

// file: ipic_top.sv
// external pin interrupt controller with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module ipic_top #(
    parameter int NPIN = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pins
    input  wire logic [7:0]  ext_request_pin,
    input  wire logic        nonmask_pin,
    input  wire logic        manual_reset_pin,
    // to the core
    output logic             core_req_valid,
    output logic      [2:0]  core_req_src,
    output logic      [2:0]  core_req_level,
    output logic             nonmask_req,
    output logic      [1:0]  int_mode,
    output logic             manual_reset_out,
    output logic             onchip_ram_enable,
    // interrupt line
    output logic             irq
);
    logic [7:0]           system_control_r;
    logic [7:0]           prio_r [4];
    logic [7:0]           pin_sense_high_r;
    logic [7:0]           pin_sense_low_r;
    logic [7:0]           pin_request_enable_r;
    logic [7:0]           pin_request_status_r;
    logic [7:0]           flag_seen_r;
    logic [ipic_pkg::EV_W-1:0] ev_status_r;
    logic [ipic_pkg::EV_W-1:0] ev_mask_r;
    logic [ipic_pkg::EV_W-1:0] ev_set;

    ipic_pkg::ipic_cmd_t  cmd_r;
    logic                 wr_pend_r;
    logic                 rd_pend_r;
    logic [31:0]          hrdata_r;
    logic                 hreadyout_r;
    logic [7:0]           rd_mux;
    logic [7:0]           wdat;
    logic                 take;

    logic [9:0]           pin_level;
    logic [9:0]           pin_detect;
    logic [19:0]          sense_all;
    logic [23:0]          levels;
    ipic_pkg::ipic_req_t  win;
    ipic_pkg::ipic_req_t  req_r;
    logic                 nmi_r;
    logic                 mrst_r;
    logic                 irq_r;
    logic [7:0]           pin_set;
    logic [7:0]           pin_clr;

    // true when an access hits register idx
    function automatic logic hit(input ipic_pkg::ipic_cmd_t c,
                                 input logic [29:0] idx);
        hit = (c.idx == idx);
    endfunction

    // masked merge of written data into a register
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] data,
                                         input logic [7:0] wmask);
        merge = (old & ~wmask) | (data & wmask);
    endfunction

    assign wdat = hwdata[7:0];
    assign take = hsel & hready & htrans[1];

    // address phase capture; reads get one wait state so a write just
    // before them is already visible in the read data
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_r       <= '0;
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            hreadyout_r <= 1'b1;
        end else begin
            wr_pend_r <= 1'b0;
            if (rd_pend_r) begin
                rd_pend_r   <= 1'b0;
                hreadyout_r <= 1'b1;
            end else if (take) begin
                cmd_r.write <= hwrite;
                cmd_r.idx   <= haddr[31:2];
                wr_pend_r   <= hwrite;
                rd_pend_r   <= ~hwrite;
                hreadyout_r <= hwrite;
            end
        end
    end

    // read multiplexer; unmapped and reserved bits read as zero
    always_comb begin
        rd_mux = ipic_pkg::REG8_ZERO;
        case (1'b1)
            hit(cmd_r, ipic_pkg::IDX_SYSTEM_CONTROL):
                rd_mux = system_control_r;
            hit(cmd_r, ipic_pkg::IDX_PRIO_A):       rd_mux = prio_r[0];
            hit(cmd_r, ipic_pkg::IDX_PRIO_B):       rd_mux = prio_r[1];
            hit(cmd_r, ipic_pkg::IDX_PRIO_C):       rd_mux = prio_r[2];
            hit(cmd_r, ipic_pkg::IDX_PRIO_D):       rd_mux = prio_r[3];
            hit(cmd_r, ipic_pkg::IDX_SENSE_HIGH):   rd_mux = pin_sense_high_r;
            hit(cmd_r, ipic_pkg::IDX_SENSE_LOW):    rd_mux = pin_sense_low_r;
            hit(cmd_r, ipic_pkg::IDX_PIN_ENABLE):
                rd_mux = pin_request_enable_r;
            hit(cmd_r, ipic_pkg::IDX_PIN_STATUS):
                rd_mux = pin_request_status_r;
            hit(cmd_r, ipic_pkg::IDX_EVENT_STATUS):
                rd_mux = {5'h00, ev_status_r};
            hit(cmd_r, ipic_pkg::IDX_EVENT_MASK):
                rd_mux = {5'h00, ev_mask_r};
            default: rd_mux = ipic_pkg::REG8_ZERO;
        endcase
    end

    // read data loaded in the wait cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata_r <= 32'h00000000;
        end else if (rd_pend_r) begin
            hrdata_r <= {24'h000000, rd_mux};
        end
    end

    // system control; prohibited mode codes keep the old mode
    always_ff @(posedge clk) begin
        if (rst) begin
            system_control_r <= ipic_pkg::SC_RESET;
        end else if (wr_pend_r &&
                     hit(cmd_r, ipic_pkg::IDX_SYSTEM_CONTROL)) begin
            if (wdat[ipic_pkg::SC_MODE_LO]) begin
                system_control_r <= {system_control_r[7:6],
                                     system_control_r[5:4],
                                     wdat[3:0] & ipic_pkg::SC_WMASK[3:0]};
            end else begin
                system_control_r <= merge(system_control_r, wdat,
                                          ipic_pkg::SC_WMASK);
            end
        end
    end

    // priority registers, two fields each
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                prio_r[i] <= ipic_pkg::PRIO_RESET;
            end
        end else if (wr_pend_r) begin
            if (hit(cmd_r, ipic_pkg::IDX_PRIO_A))
                prio_r[0] <= merge(prio_r[0], wdat, ipic_pkg::PRIO_WMASK);
            if (hit(cmd_r, ipic_pkg::IDX_PRIO_B))
                prio_r[1] <= merge(prio_r[1], wdat, ipic_pkg::PRIO_WMASK);
            if (hit(cmd_r, ipic_pkg::IDX_PRIO_C))
                prio_r[2] <= merge(prio_r[2], wdat, ipic_pkg::PRIO_WMASK);
            if (hit(cmd_r, ipic_pkg::IDX_PRIO_D))
                prio_r[3] <= merge(prio_r[3], wdat, ipic_pkg::PRIO_WMASK);
        end
    end

    // pin enable and sense registers
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_request_enable_r <= ipic_pkg::REG8_ZERO;
            pin_sense_high_r     <= ipic_pkg::REG8_ZERO;
            pin_sense_low_r      <= ipic_pkg::REG8_ZERO;
        end else if (wr_pend_r) begin
            if (hit(cmd_r, ipic_pkg::IDX_PIN_ENABLE))
                pin_request_enable_r <= wdat;
            if (hit(cmd_r, ipic_pkg::IDX_SENSE_HIGH))
                pin_sense_high_r <= wdat;
            if (hit(cmd_r, ipic_pkg::IDX_SENSE_LOW))
                pin_sense_low_r <= wdat;
        end
    end

    // pins 0-7 sense from the pair, nmi by its edge bit, reset pin level
    always_comb begin
        // pin 0 code at low register bits 1:0
        sense_all[15:0] = {pin_sense_high_r, pin_sense_low_r};
        // edge select picks falling or rising
        sense_all[17:16] = system_control_r[ipic_pkg::SC_NMI_EDGE] ?
                           ipic_pkg::SENSE_RISE : ipic_pkg::SENSE_FALL;
        sense_all[19:18] = ipic_pkg::SENSE_LOW_LEVEL;
    end

    ipic_pin_sense #(
        .N      (10)
    ) u_sense (
        .clk    (clk),
        .rst    (rst),
        .pin    ({manual_reset_pin, nonmask_pin, ext_request_pin}),
        .sense  (sense_all),
        .level  (pin_level),
        .detect (pin_detect)
    );

    // flag set and clear terms
    always_comb begin
        // disabled pins never raise a flag
        pin_set = pin_detect[7:0] & pin_request_enable_r;
        pin_clr = 8'h00;
        if (wr_pend_r && hit(cmd_r, ipic_pkg::IDX_PIN_STATUS)) begin
            // write 0 clears only flags already read as 1
            pin_clr = ~wdat & flag_seen_r;
        end
    end

    // request flags; a new detect beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_request_status_r <= ipic_pkg::REG8_ZERO;
            flag_seen_r          <= ipic_pkg::REG8_ZERO;
        end else begin
            pin_request_status_r <= (pin_request_status_r & ~pin_clr) |
                                    pin_set;
            if (rd_pend_r && hit(cmd_r, ipic_pkg::IDX_PIN_STATUS)) begin
                flag_seen_r <= (flag_seen_r & ~pin_clr) |
                               pin_request_status_r;
            end else begin
                flag_seen_r <= flag_seen_r & ~pin_clr;
            end
        end
    end

    // event sources for the interrupt line
    always_comb begin
        ev_set = '0;
        ev_set[ipic_pkg::EV_NMI] = pin_detect[8];
        ev_set[ipic_pkg::EV_PIN] = |pin_set;
        ev_set[ipic_pkg::EV_BAD_MODE] = wr_pend_r &&
            hit(cmd_r, ipic_pkg::IDX_SYSTEM_CONTROL) &&
            wdat[ipic_pkg::SC_MODE_LO];
    end

    // sticky event status, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            ev_status_r <= '0;
            ev_mask_r   <= '0;
        end else begin
            if (wr_pend_r && hit(cmd_r, ipic_pkg::IDX_EVENT_STATUS)) begin
                ev_status_r <= (ev_status_r & ~wdat[ipic_pkg::EV_W-1:0]) |
                               ev_set;
            end else begin
                ev_status_r <= ev_status_r | ev_set;
            end
            if (wr_pend_r && hit(cmd_r, ipic_pkg::IDX_EVENT_MASK)) begin
                ev_mask_r <= wdat[ipic_pkg::EV_W-1:0];
            end
        end
    end

    // pin i level in prio register i/2, even pin in the high field
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            // field code is the level itself
            levels[3*i +: 3] = (i % 2 == 0) ?
                prio_r[i/2][ipic_pkg::PRIO_HI_LSB +: 3] :
                prio_r[i/2][ipic_pkg::PRIO_LO_LSB +: 3];
        end
    end

    ipic_prio_resolve #(
        .N          (NPIN)
    ) u_resolve (
        .pend       (pin_request_status_r & pin_request_enable_r),
        .levels     (levels),
        .use_levels (system_control_r[5:4] == ipic_pkg::MODE_2),
        .win        (win)
    );

    // registered outputs to the core
    always_ff @(posedge clk) begin
        if (rst) begin
            req_r  <= '0;
            nmi_r  <= 1'b0;
            mrst_r <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            req_r  <= win;
            nmi_r  <= ev_status_r[ipic_pkg::EV_NMI];
            // reset pin only passes when enabled
            mrst_r <= system_control_r[ipic_pkg::SC_MRST_EN] &
                      ~pin_level[9];
            irq_r  <= |(ev_status_r & ev_mask_r);
        end
    end

    assign hrdata            = hrdata_r;
    assign hreadyout         = hreadyout_r;
    assign hresp             = 1'b0;
    assign core_req_valid    = req_r.valid;
    assign core_req_src      = req_r.src;
    assign core_req_level    = req_r.level;
    assign nonmask_req       = nmi_r;
    assign int_mode          = system_control_r[5:4];
    assign manual_reset_out  = mrst_r;
    // ram enable bit drives the ram
    assign onchip_ram_enable = system_control_r[ipic_pkg::SC_RAM_EN];
    assign irq               = irq_r;
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the pin interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [29:0] A_SC = ipic_pkg::IDX_SYSTEM_CONTROL;
    localparam logic [29:0] A_PA = ipic_pkg::IDX_PRIO_A;
    localparam logic [29:0] A_PB = ipic_pkg::IDX_PRIO_B;
    localparam logic [29:0] A_SH = ipic_pkg::IDX_SENSE_HIGH;
    localparam logic [29:0] A_SL = ipic_pkg::IDX_SENSE_LOW;
    localparam logic [29:0] A_EN = ipic_pkg::IDX_PIN_ENABLE;
    localparam logic [29:0] A_ST = ipic_pkg::IDX_PIN_STATUS;
    localparam logic [29:0] A_EV = ipic_pkg::IDX_EVENT_STATUS;
    localparam logic [29:0] A_MK = ipic_pkg::IDX_EVENT_MASK;
    logic        clk, rst, hsel, hwrite, nmi_pin, mrst_pin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, int_mode;
    logic [7:0]  pins;
    logic        hreadyout, hresp, core_req_valid, nonmask_req;
    logic        manual_reset_out, onchip_ram_enable, irq, nmi_seen;
    logic [2:0]  core_req_src, core_req_level;
    ipic_pkg::ipic_req_t taken;
    int          n_mismatch, compares;
    // device under test; the one slave's ready is the bus ready
    ipic_top ipic_top_i (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ext_request_pin(pins), .nonmask_pin(nmi_pin),
        .manual_reset_pin(mrst_pin), .core_req_valid(core_req_valid),
        .core_req_src(core_req_src), .core_req_level(core_req_level),
        .nonmask_req(nonmask_req), .int_mode(int_mode),
        .manual_reset_out(manual_reset_out),
        .onchip_ram_enable(onchip_ram_enable), .irq(irq)
    );
    // core on the far side
    ipic_core_model ipic_core_model_i (
        .clk(clk), .rst(rst), .req_valid(core_req_valid),
        .req_src(core_req_src), .req_level(core_req_level),
        .nmi_req(nonmask_req), .taken(taken), .nmi_seen(nmi_seen)
    );
    // free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // counts a comparison and reports a mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // a stuck ready would hang the run, so the wait is bounded
    task automatic wait_ready;
        int k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            $display("Error at %0t: ready %h expected %h", $time,
                     hreadyout, 1'b1);
            report_and_stop();
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [29:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {idx, 2'b00};
        htrans <= ipic_pkg::HTRANS_NONSEQ_BIT;
        hwrite <= w;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [29:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [29:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask
    task automatic t_reset;
        rdc(A_SC, 32'h01);
        rdc(A_PA, 32'h77);
        rdc(A_ST, 32'h00);
        rdc(30'h3, 32'h00);
        $display("test reset done");
    endtask
    task automatic t_sysctl;
        wr(A_SC, 8'h2c);
        rdc(A_SC, 32'h2c);
        chk({29'h0, hresp, int_mode}, 32'h2);
        chk({31'h0, onchip_ram_enable}, 32'h0);
        wr(A_SC, 8'h1d);
        rdc(A_SC, 32'h2d);
        rdc(A_EV, 32'h04);
        mrst_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk({31'h0, manual_reset_out}, 32'h1);
        wr(A_SC, 8'h29);
        repeat (3) @(posedge clk);
        chk({31'h0, manual_reset_out}, 32'h0);
        mrst_pin <= 1'b1;
        wr(A_EV, 8'h07);
        $display("test system control done");
    endtask
    // rising edge selected, falling edge ignored; then falling edge selected and seen
    task automatic t_nmi;
        nmi_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk({31'h0, nmi_seen}, 32'h0);
        nmi_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk({31'h0, nmi_seen}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(A_EV, 8'h01);
        wr(A_SC, 8'h21);
        nmi_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk({31'h0, nmi_seen}, 32'h1);
        $display("test nmi done");
    endtask
    // pin senses, enables, flags and priority
    task automatic t_pins;
        wr(A_MK, 8'h02);
        wr(A_PA, 8'hff);
        rdc(A_PA, 32'h77);
        wr(A_PA, 8'h25);
        wr(A_PB, 8'h63);
        wr(A_SH, 8'he4);
        rdc(A_SH, 32'he4);
        wr(A_SL, 8'h27);
        wr(A_EN, 8'h0f);
        // pin 0 both, 1 falling, 2 rising, 3 low level, 4-7 disabled
        pins <= 8'h00;
        repeat (8) @(posedge clk);
        rdc(A_ST, 32'h0b);
        chk({25'h0, taken}, 32'h4d);
        chk({31'h0, irq}, 32'h1);
        wr(A_ST, 8'h00);
        rdc(A_ST, 32'h08);
        pins <= 8'hff;
        repeat (8) @(posedge clk);
        // flags 0 and 2 never read as one, so a zero must not clear them
        wr(A_ST, 8'h08);
        rdc(A_ST, 32'h0d);
        chk({25'h0, taken}, 32'h56);
        wr(A_SC, 8'h09);
        repeat (3) @(posedge clk);
        chk({25'h0, taken}, 32'h42);
        wr(A_ST, 8'h00);
        rdc(A_ST, 32'h00);
        wr(A_EV, 8'h02);
        repeat (3) @(posedge clk);
        chk({30'h0, core_req_valid, irq}, 32'h0);
        $display("test pins done");
    endtask
    // main sequence: 20 cycles of reset, then the scenarios
    initial begin
        rst      = 1'b1;
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hwdata   = 32'h0;
        pins     = 8'hff;
        nmi_pin  = 1'b1;
        mrst_pin = 1'b1;
        n_mismatch = 0;
        compares   = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_sysctl();
        t_nmi();
        t_pins();
        report_and_stop();
    end
endmodule
`default_nettype wire
